// File: irq_flag_pkg.sv
// Purpose: constants and carriers for the interrupt flag status bank
// Assumes: 32-bit ahb-lite data, one register per aligned word
// Notes:   flag registers are 16 bits wide, upper bits read as zero
package irq_flag_pkg;

  localparam int          FLAG_W = 16;
  localparam int          ADDR_W = 8;

  // register byte addresses
  localparam logic [7:0]  OFS_FLAGS_0  = 8'h00;
  localparam logic [7:0]  OFS_FLAGS_1  = 8'h04;
  localparam logic [7:0]  OFS_FLAGS_2  = 8'h08;
  localparam logic [7:0]  OFS_ENABLE_0 = 8'h0c;
  localparam logic [7:0]  OFS_ENABLE_1 = 8'h10;
  localparam logic [7:0]  OFS_ENABLE_2 = 8'h14;
  localparam logic [7:0]  OFS_EVT_STAT = 8'h18;
  localparam logic [7:0]  OFS_EVT_MASK = 8'h1c;

  // implemented-bit masks; zero bits are unimplemented
  localparam logic [15:0] IMPL_FLAGS_0 = 16'h000f;
  localparam logic [15:0] IMPL_FLAGS_1 = 16'hfffb;
  localparam logic [15:0] IMPL_FLAGS_2 = 16'hdfff;

  // reset values
  localparam logic [15:0] FLAGS_RST    = 16'h0000;
  localparam logic [15:0] ENABLE_RST   = 16'h0000;
  localparam logic [2:0]  EVT_RST      = 3'h0;

  // ahb encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  // first flag register: source event pulses, bit 3 down to 0
  typedef struct packed {
    logic timer1_req_flag;
    logic compare1_req_flag;
    logic capture1_req_flag;
    logic ext_pin0_req_flag;
  } src0_t;

  // second flag register, bit 15 down to 0 except unimplemented bit 2
  typedef struct packed {
    logic serial2_tx_req_flag;
    logic serial2_rx_req_flag;
    logic ext_pin2_req_flag;
    logic timer5_req_flag;
    logic timer4_req_flag;
    logic compare4_req_flag;
    logic compare3_req_flag;
    logic dma_ch2_done_flag;
    logic capture8_req_flag;
    logic capture7_req_flag;
    logic adc2_done_flag;
    logic ext_pin1_req_flag;
    logic pin_change_req_flag;
    logic i2c1_master_req_flag;
    logic i2c1_slave_req_flag;
  } src1_t;

  // third flag register, bit 15 down to 0 except unimplemented bit 13
  typedef struct packed {
    logic timer6_req_flag;
    logic dma_ch4_done_flag;
    logic compare8_req_flag;
    logic compare7_req_flag;
    logic compare6_req_flag;
    logic compare5_req_flag;
    logic capture6_req_flag;
    logic capture5_req_flag;
    logic capture4_req_flag;
    logic capture3_req_flag;
    logic dma_ch3_done_flag;
    logic can1_event_req_flag;
    logic can1_rx_ready_flag;
    logic spi2_event_req_flag;
    logic spi2_error_req_flag;
  } src2_t;

  // all event pulses together
  typedef struct packed {
    src2_t s2;
    src1_t s1;
    src0_t s0;
  } src_evt_t;

endpackage : irq_flag_pkg

// File: irq_flag_bank.sv
// Purpose: interrupt request flag bank with ahb-lite register access
// Assumes: single word transfers, source pulses on hclk, one cycle wide
// Notes:   zero wait state slave, always OKAY
// Function
// - a flag reads 1 after its source requested, 0 while nothing pending
// - all implemented flag bits are software read/write and reset to 0
// - bit 2 of second and bit 13 of third register read 0, ignore writes
// - first register bits 3..0: timer1, compare1, capture1, external pin 0
// - second register bits 15..8: serial2 tx/rx, pin2, timer5/4, cmp4/3, dma2
// - second register bits 7..3: capture8/7, adc2, pin1, change; bits 1,0 i2c1
// - third register bit 15 timer6, 14 dma4, 12..9 compare8..5, 8 capture6
// - third register bits 7..4: capture5, capture4, capture3, dma channel 3
// - third register bits 3..0: can1 event, can1 rx ready, spi2 event, error
`timescale 1ns/10ps
module irq_flag_bank
  import irq_flag_pkg::*;
(
  input  wire logic                hclk,        // system clock
  input  wire logic                hresetn,     // async reset, active low
  input  wire logic                hsel,        // slave select
  input  wire logic [ADDR_W-1:0]   haddr,       // byte address
  input  wire logic [1:0]          htrans,      // transfer type
  input  wire logic                hwrite,      // write when high
  input  wire logic [2:0]          hsize,       // transfer size
  input  wire logic                hready,      // bus ready in
  input  wire logic [31:0]         hwdata,      // write data
  output logic      [31:0]         hrdata,      // read data
  output logic                     hreadyout,   // slave ready
  output logic                     hresp,       // response, always okay
  input  wire irq_flag_pkg::src_evt_t src_evt,  // one-cycle source pulses
  output logic      [2:0]          cpu_req,     // enabled request per register
  output logic                     irq          // summary interrupt level
);

  // bit position of each source pulse inside its flag register, skipping the hole
  function automatic logic [15:0] expand1(input src1_t s);
    expand1 = {s[14:2], 1'b0, s[1:0]};
  endfunction : expand1

  function automatic logic [15:0] expand2(input src2_t s);
    expand2 = {s[14:13], 1'b0, s[12:0]};
  endfunction : expand2

  logic [15:0] flags_r   [3];
  logic [15:0] enable_r  [3];
  logic [15:0] set_vec   [3];
  logic [15:0] impl      [3];
  logic [2:0]  evt_stat_r;
  logic [2:0]  evt_mask_r;
  logic [2:0]  req_now;
  logic [2:0]  req_prev_r;

  // address phase capture
  logic              wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic              rd_go;
  logic              wr_go;

  // hardware set vectors, one per register, mapped to documented bits
  assign set_vec[0] = {12'h000, src_evt.s0};
  assign set_vec[1] = expand1(src_evt.s1);
  assign set_vec[2] = expand2(src_evt.s2);
  assign impl[0]    = IMPL_FLAGS_0;
  assign impl[1]    = IMPL_FLAGS_1;
  assign impl[2]    = IMPL_FLAGS_2;

  // word-sized transfers only are acted on; others complete silently
  assign rd_go = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)
                 && !hwrite && (hsize == HSIZE_WORD);
  assign wr_go = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)
                 && hwrite && (hsize == HSIZE_WORD);

  // zero wait state slave
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // write address held into the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else if (hready)
    begin
      wr_pend_r <= wr_go;
      wr_addr_r <= haddr;
    end
  end

  // flag storage, set by pulses or a written 1, cleared by a written 0
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_flag
      logic        hit;
      logic [15:0] nxt;
      always_comb
      begin
        hit = wr_pend_r && (wr_addr_r == OFS_FLAGS_0 + 8'(4 * g));
        nxt = flags_r[g];
        if (hit)
          nxt = hwdata[15:0];
        nxt = (nxt | set_vec[g]) & impl[g];
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          flags_r[g] <= FLAGS_RST;
        else
          flags_r[g] <= nxt;
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          enable_r[g] <= ENABLE_RST;
        else if (wr_pend_r && (wr_addr_r == OFS_ENABLE_0 + 8'(4 * g)))
          enable_r[g] <= hwdata[15:0] & impl[g];
      end

      // a request only reaches the processor when enabled
      assign req_now[g] = |(flags_r[g] & enable_r[g]);
    end
  endgenerate

  assign cpu_req = req_now;

  // rising edge of each register's request feeds the sticky event status
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      req_prev_r <= EVT_RST;
    else
      req_prev_r <= req_now;
  end

  // status read clears; a new event in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      evt_stat_r <= EVT_RST;
    else
    begin
      if (rd_go && haddr == OFS_EVT_STAT)
        evt_stat_r <= req_now & ~req_prev_r;
      else
        evt_stat_r <= evt_stat_r | (req_now & ~req_prev_r);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      evt_mask_r <= EVT_RST;
    else if (wr_pend_r && wr_addr_r == OFS_EVT_MASK)
      evt_mask_r <= hwdata[2:0];
  end

  assign irq = |(evt_stat_r & evt_mask_r);

  // read data registered from the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (rd_go)
    begin
      case (haddr)
        OFS_FLAGS_0:  hrdata <= {16'h0000, flags_r[0]};
        OFS_FLAGS_1:  hrdata <= {16'h0000, flags_r[1]};
        OFS_FLAGS_2:  hrdata <= {16'h0000, flags_r[2]};
        OFS_ENABLE_0: hrdata <= {16'h0000, enable_r[0]};
        OFS_ENABLE_1: hrdata <= {16'h0000, enable_r[1]};
        OFS_ENABLE_2: hrdata <= {16'h0000, enable_r[2]};
        OFS_EVT_STAT: hrdata <= {29'h0, evt_stat_r};
        OFS_EVT_MASK: hrdata <= {29'h0, evt_mask_r};
        default:      hrdata <= '0;
      endcase
    end
  end

endmodule : irq_flag_bank

// File: irq_src_model.sv
// Purpose: event source model driving one-cycle request pulses
// Assumes: one request at a time, on hclk
// Notes: quiet between requests, no stray pulses
`timescale 1ns/10ps
module irq_src_model
  import irq_flag_pkg::*;
(
  input  wire logic     hclk,    // clock
  input  wire logic     hresetn, // reset, active low
  input  wire logic     go,      // fire request
  input  wire logic [5:0] idx,   // source index
  output irq_flag_pkg::src_evt_t src_evt // pulses
);
  // one pulse per request, low otherwise so a stuck flag shows
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      src_evt <= '0;
    else
      src_evt <= go ? src_evt_t'($bits(src_evt_t)'(1) << idx) : '0;
endmodule : irq_src_model

// File: irq_flag_checker.sv
// Purpose: read-data checks on the flag bank bus port
// Assumes: zero wait state, registered read data
// Notes: only word reads count as reads
`timescale 1ns/10ps
module irq_flag_checker
  import irq_flag_pkg::*;
(
  input wire logic              hclk,      // clock
  input wire logic              hresetn,   // reset
  input wire logic              hsel,      // select
  input wire logic [ADDR_W-1:0] haddr,     // address
  input wire logic [1:0]        htrans,    // transfer
  input wire logic              hwrite,    // write
  input wire logic [2:0]        hsize,     // size
  input wire logic              hready,    // ready in
  input wire logic [31:0]       hrdata,    // read data
  input wire logic              hreadyout, // ready out
  input wire logic              hresp      // response
);
  logic       rd_r;
  logic [7:0] adr_r;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // remember a word read address phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rd_r <= 1'b0;
    else
      rd_r <= hsel && hready && htrans[1] && !hwrite && hsize == HSIZE_WORD;
  // address of that phase
  always_ff @(posedge hclk)
    adr_r <= haddr;
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or okay");
  a_upper_zero: assert property (rd_r |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_hole_one: assert property (rd_r && adr_r == OFS_FLAGS_1 |-> !hrdata[2])
    else $error("hole in second register set");
  a_hole_two: assert property (rd_r && adr_r == OFS_FLAGS_2 |-> !hrdata[13])
    else $error("hole in third register set");
  a_top_zero: assert property (rd_r && adr_r == OFS_FLAGS_0 |-> hrdata[15:4] == 12'h000)
    else $error("first register high bits set");
  a_unmapped_zero: assert property (rd_r && adr_r >= 8'h20 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_stat_width: assert property (rd_r && adr_r == OFS_EVT_STAT |-> hrdata[31:3] == 29'h0)
    else $error("status read too wide");
  a_rdata_hold: assert property (!rd_r |-> $stable(hrdata)) else $error("read data moved");
endmodule : irq_flag_checker
bind irq_flag_bank irq_flag_checker i_irq_flag_checker (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// File: irq_flag_bank_tb.sv
// Purpose: self-checking bench for the flag bank
// Assumes: ahb-lite single transfers, all word-sized except one byte write, one source model
// Notes: seed fixed, random flag data plus corners
`timescale 1ns/10ps
module irq_flag_bank_tb;
  import irq_flag_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hwrite = 1'b0;
  logic        go = 1'b0;
  logic [5:0]  idx = 6'h00;
  logic [7:0]  haddr = 8'h00;
  logic [2:0]  hsz = HSIZE_WORD;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, d;
  logic [2:0]  cpu_req;
  logic        hreadyout, hresp, irq;
  src_evt_t    src_evt;
  logic [15:0] impl [3] = '{16'h000f, 16'hfffb, 16'hdfff};
  int          failures = 0, checked = 0, cycles = 0, seed = 45;
  always #5 hclk = ~hclk;
  irq_flag_bank i_irq_flag_bank (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsz), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_evt(src_evt),
    .cpu_req(cpu_req), .irq(irq));
  irq_src_model i_irq_src_model (.hclk(hclk), .hresetn(hresetn), .go(go), .idx(idx),
    .src_evt(src_evt));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // write; p >= 0 fires that source during the data phase
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input int p);
    @(posedge hclk);
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    go <= p >= 0;
    idx <= 6'(p);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    go <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : wr
  // read and compare at the data-phase edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge hclk);
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk(hrdata, exp);
  endtask : rd
  // source index to register*16 + bit, skipping the two holes
  function automatic int pos(input int i);
    if (i < 4)
      return i;
    if (i < 19)
      return 12 + i + (i >= 6);
    return 13 + i + (i >= 32);
  endfunction : pos
  task automatic wrap_up();
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // hang guard, far above the roughly 670 cycles needed
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and one unmapped word
    for (int a = 0; a <= 32; a += 4)
      rd(8'(a), 32'h0);
    // every source sets only its own bit, cleared by writing zero
    for (int i = 0; i < 34; i++)
    begin
      wr(8'h20, 32'h0, i);
      rd(8'(pos(i) / 16 * 4), 32'h1 << (pos(i) % 16));
      wr(8'(pos(i) / 16 * 4), 32'h0, -1);
      rd(8'(pos(i) / 16 * 4), 32'h0);
    end
    // all ones first, then random data
    for (int n = 0; n < 30; n++)
    begin
      d = n < 3 ? 32'hffffffff : $random(seed);
      wr(8'(n % 3 * 4), d, -1);
      rd(8'(n % 3 * 4), d & {16'h0, impl[n % 3]});
    end
    // pulse during a clearing write keeps the flag
    wr(OFS_FLAGS_0, 32'h8, -1);
    wr(OFS_FLAGS_0, 32'h0, 3);
    rd(OFS_FLAGS_0, 32'h8);
    // enable, mask, read-clear of the summary
    wr(OFS_ENABLE_0, 32'h8, -1);
    #1 chk(32'(cpu_req), 32'h1);
    chk(32'(irq), 32'h0);
    wr(OFS_EVT_MASK, 32'h1, -1);
    #1 chk(32'(irq), 32'h1);
    rd(OFS_EVT_STAT, 32'h1);
    #1 chk(32'(irq), 32'h0);
    rd(OFS_EVT_STAT, 32'h0);
    wr(OFS_FLAGS_0, 32'h0, -1);
    #1 chk(32'(cpu_req), 32'h0);
    // a byte-sized write must leave the flags alone
    hsz <= 3'h0;
    wr(OFS_FLAGS_0, 32'hf, -1);
    hsz <= HSIZE_WORD;
    rd(OFS_FLAGS_0, 32'h0);
    // enable registers keep only implemented positions
    for (int g = 0; g < 3; g++)
    begin
      wr(8'(g * 4 + 12), 32'hffffffff, -1);
      rd(8'(g * 4 + 12), {16'h0, impl[g]});
    end
    rd(OFS_EVT_MASK, 32'h1);
    wrap_up();
  end
endmodule : irq_flag_bank_tb
